// File: pkg/dlth_map.svh
// register offsets, field positions, reset values and timing counts of the
// dual line trigger handshake block; included by the package only
`ifndef DLTH_MAP_SVH
`define DLTH_MAP_SVH

// ==========================================================================
// clock and timing
`define DLTH_CLK_HZ        10000000
`define DLTH_FILTER_US     100
// least rejection width, rounded up to whole cycles
`define DLTH_FILTER_CYC    ((`DLTH_FILTER_US * `DLTH_CLK_HZ + 999999) / 1000000)
`define DLTH_TW            20

// ==========================================================================
// register byte offsets
`define DLTH_OFF_CTRL      8'h00
`define DLTH_OFF_FILTER    8'h04
`define DLTH_OFF_CAPTURE   8'h08
`define DLTH_OFF_PROCESS   8'h0C
`define DLTH_OFF_STB_POINT 8'h10
`define DLTH_OFF_STB_LEN   8'h14
`define DLTH_OFF_RESULT0   8'h18
`define DLTH_OFF_RESULT1   8'h1C
`define DLTH_OFF_STATUS    8'h20
`define DLTH_OFF_ERROR     8'h24
`define DLTH_OFF_COUNT     8'h28

// ==========================================================================
// control fields
`define DLTH_CTRL_LIVE     0
`define DLTH_CTRL_RANDOM   1
`define DLTH_CTRL_POLAR    2
`define DLTH_CTRL_FLOWOUT  3
`define DLTH_CTRL_RUNWIN   4
// result fields
`define DLTH_RES_PASS      8

// ==========================================================================
// reset values
`define DLTH_CTRL_RST      5'h0A
`define DLTH_CAPTURE_RST   20'h00FA0
`define DLTH_PROCESS_RST   20'h00FA0
`define DLTH_STB_POINT_RST 20'h007D0
`define DLTH_STB_LEN_RST   20'h007D0
`define DLTH_RESP_OKAY     2'h0
`define DLTH_RESP_SLVERR   2'h2

`endif

// File: pkg/dlth_pkg.sv
// types shared by the trigger filter and the handshake top
// assumes dlth_map.svh is on the include path
`include "dlth_map.svh"

package dlth_pkg;

  // ========================================================================
  // per line sequencer states
  typedef enum logic [3:0] {
    DLTH_IDLE     = 4'b0001,
    DLTH_WAIT_CAP = 4'b0010,
    DLTH_CAPTURE  = 4'b0100,
    DLTH_PROCESS  = 4'b1000
  } dlth_lstate_type;

  typedef struct packed {
    dlth_lstate_type         state;
    logic [`DLTH_TW-1:0]     timer;
    logic [`DLTH_TW-1:0]     scnt;
    logic                    strobe;
    logic                    strobe_done;
    logic                    busy;
    logic                    ready;
    logic                    verdict;
    logic [7:0]              data;
    logic [15:0]             count;
  } dlth_line_type;

  typedef struct packed {
    logic [1:0]              sync;
    logic                    stable;
    logic [`DLTH_TW-1:0]     cnt;
    logic                    rise;
  } dlth_filt_type;

  typedef struct packed {
    dlth_line_type [1:0]     line;
    logic [4:0]              ctrl;
    logic [`DLTH_TW-1:0]     filt_len;
    logic [`DLTH_TW-1:0]     cap_len;
    logic [`DLTH_TW-1:0]     proc_len;
    logic [`DLTH_TW-1:0]     stb_point;
    logic [`DLTH_TW-1:0]     stb_len;
    logic [1:0][8:0]         res;
    logic                    err;
    logic                    working1;
    logic                    awready;
    logic                    aw_hold;
    logic [7:0]              awaddr;
    logic                    wready;
    logic                    w_hold;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } dlth_top_type;

endpackage : dlth_pkg

// File: verilog/dlth_trig_filter.sv
// trigger pin synchroniser, noise filter and rising edge detector
// assumes trig_pin is asynchronous and filt_len comes from the clk domain
module dlth_trig_filter
  import dlth_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                trig_pin,
  input  wire logic [`DLTH_TW-1:0] filt_len,
  output logic                     trig_rise
);

  dlth_filt_type r_reg;
  dlth_filt_type r_next;

  // ========================================================================
  // filter
  always_comb begin
    r_next = r_reg;
    r_next.sync = {r_reg.sync[0], trig_pin};
    r_next.rise = 1'b0;
    // level must stay changed for filt_len cycles before it counts
    if (r_reg.sync[1] != r_reg.stable) begin
      if (`DLTH_TW'(r_reg.cnt + `DLTH_TW'(1)) >= filt_len) begin
        r_next.stable = r_reg.sync[1];
        r_next.cnt    = '0;
        r_next.rise   = r_reg.sync[1];
      end else begin
        r_next.cnt = `DLTH_TW'(r_reg.cnt + `DLTH_TW'(1));
      end
    end else begin
      r_next.cnt = '0;
    end
    if (srst) begin
      r_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    r_reg <= r_next;
  end

  assign trig_rise = r_reg.rise;

endmodule : dlth_trig_filter

// File: verilog/dlth_top.sv
// dual line trigger handshake: two measurement lines with ready, busy,
// verdict, result bits and strobe pins, configured over AXI4-Lite
// assumes the trigger pins are asynchronous and the bus runs on clk
module dlth_top
  import dlth_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        line0_trigger_in,
  input  wire logic        line1_trigger_in,
  output logic             line0_accept_flag,
  output logic             line1_accept_flag,
  output logic             line0_working_flag,
  output logic             line1_working_flag,
  output logic             line0_overall_verdict,
  output logic             line1_overall_verdict,
  output logic [7:0]       line0_result_bits,
  output logic [7:0]       line1_result_bits,
  output logic             line0_result_strobe,
  output logic             line1_result_strobe,
  output logic             trigger_error
);

  dlth_top_type r_reg;
  dlth_top_type r_next;
  logic [1:0]   trig_pins;
  logic [1:0]   trig_rise;

  // ========================================================================
  // trigger filters
  assign trig_pins = {line1_trigger_in, line0_trigger_in};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      dlth_trig_filter u_filt (
        .clk       (clk),
        .srst      (srst),
        .trig_pin  (trig_pins[g]),
        .filt_len  (r_reg.filt_len),
        .trig_rise (trig_rise[g])
      );
    end
  endgenerate

  // ========================================================================
  // helpers
  function automatic dlth_top_type dlth_reset_state();
    dlth_top_type s;
    s           = '0;
    s.line[0].state = DLTH_IDLE;
    s.line[1].state = DLTH_IDLE;
    s.ctrl      = `DLTH_CTRL_RST;
    s.filt_len  = `DLTH_TW'(`DLTH_FILTER_CYC);
    s.cap_len   = `DLTH_CAPTURE_RST;
    s.proc_len  = `DLTH_PROCESS_RST;
    s.stb_point = `DLTH_STB_POINT_RST;
    s.stb_len   = `DLTH_STB_LEN_RST;
    return s;
  endfunction : dlth_reset_state

  function automatic logic dlth_mapped(input logic [7:0] a);
    return (a == `DLTH_OFF_CTRL)    || (a == `DLTH_OFF_FILTER)    ||
           (a == `DLTH_OFF_CAPTURE) || (a == `DLTH_OFF_PROCESS)   ||
           (a == `DLTH_OFF_STB_POINT) || (a == `DLTH_OFF_STB_LEN) ||
           (a == `DLTH_OFF_RESULT0) || (a == `DLTH_OFF_RESULT1)   ||
           (a == `DLTH_OFF_STATUS)  || (a == `DLTH_OFF_ERROR)     ||
           (a == `DLTH_OFF_COUNT);
  endfunction : dlth_mapped

  function automatic logic [31:0] dlth_rdmux(input dlth_top_type s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `DLTH_OFF_CTRL:      v = {27'h0, s.ctrl};
      `DLTH_OFF_FILTER:    v = {12'h000, s.filt_len};
      `DLTH_OFF_CAPTURE:   v = {12'h000, s.cap_len};
      `DLTH_OFF_PROCESS:   v = {12'h000, s.proc_len};
      `DLTH_OFF_STB_POINT: v = {12'h000, s.stb_point};
      `DLTH_OFF_STB_LEN:   v = {12'h000, s.stb_len};
      `DLTH_OFF_RESULT0:   v = {23'h0, s.res[0]};
      `DLTH_OFF_RESULT1:   v = {23'h0, s.res[1]};
      `DLTH_OFF_STATUS:    v = {24'h0, s.line[1].strobe, s.line[0].strobe,
                                s.line[1].busy, s.line[0].busy,
                                s.line[1].ready, s.line[0].ready,
                                s.working1, s.err};
      `DLTH_OFF_ERROR:     v = {31'h0, s.err};
      `DLTH_OFF_COUNT:     v = {s.line[1].count, s.line[0].count};
      default:             v = 32'h0000_0000;
    endcase
    return v;
  endfunction : dlth_rdmux

  function automatic logic [31:0] dlth_wmerge(input logic [31:0] old,
                                              input logic [31:0] din,
                                              input logic [3:0]  strb);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        v[b*8 +: 8] = din[b*8 +: 8];
      end
    end
    return v;
  endfunction : dlth_wmerge

  // ========================================================================
  // next state
  always_comb begin
    logic        cap_taken;
    logic        start_stb;
    logic        live;
    logic [31:0] wv;
    cap_taken = 1'b0;
    start_stb = 1'b0;
    live      = r_reg.ctrl[`DLTH_CTRL_LIVE];
    wv        = 32'h0000_0000;
    r_next    = r_reg;

    // ---- register bus, write side; address and data taken in either order
    if (s_axi_awvalid && r_reg.awready) begin
      r_next.aw_hold = 1'b1;
      r_next.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.wready) begin
      r_next.w_hold = 1'b1;
      r_next.wdata  = s_axi_wdata;
      r_next.wstrb  = s_axi_wstrb;
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.aw_hold && r_reg.w_hold && !r_reg.bvalid) begin
      r_next.aw_hold = 1'b0;
      r_next.w_hold  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = dlth_mapped(r_reg.awaddr) ? `DLTH_RESP_OKAY : `DLTH_RESP_SLVERR;
      wv = dlth_wmerge(dlth_rdmux(r_reg, r_reg.awaddr), r_reg.wdata, r_reg.wstrb);
      case (r_reg.awaddr)
        `DLTH_OFF_CTRL:      r_next.ctrl      = wv[4:0];
        `DLTH_OFF_FILTER:    r_next.filt_len  = wv[`DLTH_TW-1:0];
        `DLTH_OFF_CAPTURE:   r_next.cap_len   = wv[`DLTH_TW-1:0];
        `DLTH_OFF_PROCESS:   r_next.proc_len  = wv[`DLTH_TW-1:0];
        `DLTH_OFF_STB_POINT: r_next.stb_point = wv[`DLTH_TW-1:0];
        `DLTH_OFF_STB_LEN:   r_next.stb_len   = wv[`DLTH_TW-1:0];
        `DLTH_OFF_RESULT0:   r_next.res[0]    = wv[8:0];
        `DLTH_OFF_RESULT1:   r_next.res[1]    = wv[8:0];
        // write one to clear; a same cycle trigger error still sets below
        `DLTH_OFF_ERROR: begin
          if (r_reg.wstrb[0] && r_reg.wdata[0]) begin
            r_next.err = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    r_next.awready = !r_next.aw_hold && !r_next.bvalid;
    r_next.wready  = !r_next.w_hold && !r_next.bvalid;

    // ---- register bus, read side
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rdata  = dlth_rdmux(r_reg, s_axi_araddr);
      r_next.rresp  = dlth_mapped(s_axi_araddr) ? `DLTH_RESP_OKAY : `DLTH_RESP_SLVERR;
    end
    r_next.arready = !r_next.rvalid;

    // ---- measurement lines; the camera is one shared resource
    for (int i = 0; i < 2; i++) begin
      if (r_reg.line[i].state == DLTH_CAPTURE) begin
        cap_taken = 1'b1;
      end
    end
    for (int i = 0; i < 2; i++) begin
      start_stb = 1'b0;
      if (trig_rise[i] && r_reg.line[i].state != DLTH_IDLE) begin
        r_next.err = 1'b1;
      end
      unique case (r_reg.line[i].state)
        DLTH_IDLE: begin
          if (trig_rise[i]) begin
            r_next.line[i].state       = DLTH_WAIT_CAP;
            r_next.line[i].strobe_done = 1'b0;
            r_next.line[i].count       = 16'(r_reg.line[i].count + 16'h0001);
          end
        end
        DLTH_WAIT_CAP: begin
          // line 0 wins a tie, line 1 waits one capture
          if (!cap_taken) begin
            cap_taken              = 1'b1;
            r_next.line[i].state   = DLTH_CAPTURE;
            r_next.line[i].timer   = '0;
          end
        end
        DLTH_CAPTURE: begin
          r_next.line[i].timer = `DLTH_TW'(r_reg.line[i].timer + `DLTH_TW'(1));
          if (r_next.line[i].timer >= r_reg.cap_len) begin
            r_next.line[i].state = DLTH_PROCESS;
            r_next.line[i].timer = '0;
          end
        end
        DLTH_PROCESS: begin
          r_next.line[i].timer = `DLTH_TW'(r_reg.line[i].timer + `DLTH_TW'(1));
          // output step may fall inside processing
          if (r_reg.line[i].timer >= r_reg.stb_point) begin
            start_stb = 1'b1;
          end
          if (r_next.line[i].timer >= r_reg.proc_len) begin
            r_next.line[i].state   = DLTH_IDLE;
            start_stb              = 1'b1;
            // verdict set as busy falls; polarity select
            r_next.line[i].verdict = r_reg.res[i][`DLTH_RES_PASS] ^
                                     r_reg.ctrl[`DLTH_CTRL_POLAR];
          end
        end
      endcase

      // ---- result strobe
      if (r_reg.line[i].strobe) begin
        r_next.line[i].scnt = `DLTH_TW'(r_reg.line[i].scnt + `DLTH_TW'(1));
        if (r_next.line[i].scnt >= r_reg.stb_len) begin
          r_next.line[i].strobe = 1'b0;
        end
      end
      // strobe only with an output step, once per measurement
      if (start_stb && r_reg.ctrl[`DLTH_CTRL_FLOWOUT] && !r_reg.line[i].strobe_done) begin
        // strobe held for the programmed length
        r_next.line[i].strobe      = 1'b1;
        r_next.line[i].strobe_done = 1'b1;
        r_next.line[i].scnt        = '0;
        r_next.line[i].data        = r_reg.res[i][7:0];
      end

      r_next.line[i].busy  = r_next.line[i].state != DLTH_IDLE;
      // accept when idle; live view forces low
      r_next.line[i].ready = (r_next.line[i].state == DLTH_IDLE) && !live;
    end

    // line 1 pin carries run window outside random mode
    // random mode shows line 1 busy
    r_next.working1 = r_reg.ctrl[`DLTH_CTRL_RANDOM] ? r_next.line[1].busy
                                                    : r_reg.ctrl[`DLTH_CTRL_RUNWIN];

    if (srst) begin
      r_next = dlth_reset_state();
    end
  end

  always_ff @(posedge clk) begin
    r_reg <= r_next;
  end

  // ========================================================================
  // outputs, all straight from r_reg
  assign s_axi_awready         = r_reg.awready;
  assign s_axi_wready          = r_reg.wready;
  assign s_axi_bvalid          = r_reg.bvalid;
  assign s_axi_bresp           = r_reg.bresp;
  assign s_axi_arready         = r_reg.arready;
  assign s_axi_rvalid          = r_reg.rvalid;
  assign s_axi_rdata           = r_reg.rdata;
  assign s_axi_rresp           = r_reg.rresp;
  assign line0_accept_flag     = r_reg.line[0].ready;
  assign line1_accept_flag     = r_reg.line[1].ready;
  assign line0_working_flag    = r_reg.line[0].busy;
  assign line1_working_flag    = r_reg.working1;
  assign line0_overall_verdict = r_reg.line[0].verdict;
  assign line1_overall_verdict = r_reg.line[1].verdict;
  assign line0_result_bits     = r_reg.line[0].data;
  assign line1_result_bits     = r_reg.line[1].data;
  assign line0_result_strobe   = r_reg.line[0].strobe;
  assign line1_result_strobe   = r_reg.line[1].strobe;
  assign trigger_error         = r_reg.err;

endmodule : dlth_top

// File: dv/dlth_asserts.sv
// port level assertions for dlth_top
// assumes the single clock clk and the synchronous active high srst
module dlth_asserts (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       line0_accept_flag,
  input wire logic       line1_accept_flag,
  input wire logic       line0_working_flag,
  input wire logic       line0_overall_verdict,
  input wire logic [7:0] line0_result_bits,
  input wire logic       line0_result_strobe,
  input wire logic       trigger_error
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // ==========================================================================
  // bus handshakes
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    ##[1:2] s_axi_bvalid;
  endsequence
  a_write_answer: assert property (wr_taken |-> wr_answer)
    else $error("write response late");
  a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read data late");

  // ==========================================================================
  // line outputs
  a_accept_idle: assert property (line0_accept_flag |-> !line0_working_flag)
    else $error("accept flag while working");
  a_verdict_hold: assert property (
    !$fell(line0_working_flag) |-> $stable(line0_overall_verdict))
    else $error("verdict moved outside working fall");
  a_bits_hold: assert property (
    !$rose(line0_result_strobe) && !$past(srst) |-> $stable(line0_result_bits))
    else $error("result bits moved without strobe");
  a_strobe_cause: assert property ($rose(line0_result_strobe) |->
    $past(line0_working_flag) || $past(line0_working_flag, 2))
    else $error("strobe without measurement");
  a_error_cause: assert property ($rose(trigger_error) |->
    !$past(line0_accept_flag) || !$past(line1_accept_flag))
    else $error("error while both lines accept");
endmodule : dlth_asserts

// File: dv/dlth_plc_model.sv
// trigger source standing for the external controller of both lines
// assumes its tasks are called from procedures timed on clk
module dlth_plc_model #(
  parameter int HOLD_CYC = 5000
) (
  input  wire logic clk,
  input  wire logic line0_working_flag,
  input  wire logic line1_working_flag,
  output logic      line0_trigger_in,
  output logic      line1_trigger_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] trig_reg = 2'b00;

  assign line0_trigger_in = trig_reg[0];
  assign line1_trigger_in = trig_reg[1];

  // short holds only where a scenario breaks the width on purpose
  task automatic pulse(input int line, input int hold);
    @(posedge clk);
    trig_reg[line] <= 1'b1;
    repeat (hold) @(posedge clk);
    trig_reg[line] <= 1'b0;
  endtask : pulse

  // judge from the working flag, not the accept flag
  // full minimum width, 5000 cycles of 100 ns
  task automatic trigger(input int line);
    while (line ? line1_working_flag : line0_working_flag) @(posedge clk);
    pulse(line, HOLD_CYC);
  endtask : trigger
endmodule : dlth_plc_model

// File: dv/dual_line_trigger_handshake_test.sv
// self-checking bench for dlth_top: bus tasks, trigger model, line monitors
// assumes the package, the design and the checker are compiled before it
module dual_line_trigger_handshake_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CAP = 5;
  localparam int PRC = 10;
  localparam int SLEN = 4;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, res0, res1;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, trigger_error;
  logic        line0_trigger_in, line1_trigger_in, line0_accept_flag, line1_accept_flag;
  logic        line0_working_flag, line1_working_flag, line0_result_strobe, line1_result_strobe;
  logic        line0_overall_verdict, line1_overall_verdict, in_busy[2], vd;
  logic [7:0]  line0_result_bits, line1_result_bits;
  logic [7:0]  rst_off[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                               8'h20, 8'h28};
  logic [31:0] rst_val[10] = '{32'h0A, 32'h3E8, 32'hFA0, 32'hFA0, 32'h7D0, 32'h7D0, 32'h0,
                               32'h0, 32'h0C, 32'h0};
  int          bad_count, num_checks, gap, first, cnt[2], pol_m, pass_m[2];
  int          run_b[2], len_b[2], ends[2], run_s[2], len_s[2], starts[2];

  dlth_top uut (.*);
  dlth_plc_model plc (.*);

  initial begin
    forever #50 clk = ~clk;
  end

  // ==========================================================================
  // monitors: working and strobe lengths per line
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (i ? line1_working_flag : line0_working_flag) begin
        run_b[i]++;
      end else if (run_b[i] > 0) begin
        len_b[i] = run_b[i];
        run_b[i] = 0;
        ends[i]++;
        vd = i ? line1_overall_verdict : line0_overall_verdict;
        chk("verdict at end", vd, pass_m[i] ^ pol_m);
      end
      if (i ? line1_result_strobe : line0_result_strobe) begin
        if (run_s[i] == 0) begin
          in_busy[i] = i ? line1_working_flag : line0_working_flag;
          starts[i]++;
        end
        run_s[i]++;
      end else if (run_s[i] > 0) begin
        len_s[i] = run_s[i];
        run_s[i] = 0;
      end
    end
  end

  // ==========================================================================
  // bus master and reporting
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // bench model of what the verdict depends on
    if (a == `DLTH_OFF_CTRL) pol_m = v[`DLTH_CTRL_POLAR];
    if (a == `DLTH_OFF_RESULT0) pass_m[0] = v[`DLTH_RES_PASS];
    if (a == `DLTH_OFF_RESULT1) pass_m[1] = v[`DLTH_RES_PASS];
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expd);
    num_checks++;
    if (seen !== expd) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, expd, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // a hang anywhere ends the run as a mismatch
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  // ==========================================================================
  // scenarios
  initial begin
    d = $urandom(32'h49B876BD);
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    foreach (rst_off[i]) begin
      rd(rst_off[i], d, r);
      chk("reset value", d, rst_val[i]);
    end
    rd(8'h40, d, r);
    chk("unmapped read resp", r, `DLTH_RESP_SLVERR);
    wr(8'h40, 32'h1, r);
    chk("unmapped write resp", r, `DLTH_RESP_SLVERR);
    // pulse shorter than the default filter
    plc.pulse(0, 500);
    repeat (1200) @(posedge clk);
    chk("glitch rejected", ends[0], 0);
    wr(`DLTH_OFF_FILTER, 2, r);
    wr(`DLTH_OFF_CAPTURE, CAP, r);
    wr(`DLTH_OFF_PROCESS, PRC, r);
    wr(`DLTH_OFF_STB_POINT, 3, r);
    wr(`DLTH_OFF_STB_LEN, SLEN, r);
    for (int pol = 0; pol < 2; pol++) begin
      res0 = $urandom & 32'h1FF;
      res1 = $urandom & 32'h1FF;
      wr(`DLTH_OFF_RESULT0, res0, r);
      wr(`DLTH_OFF_RESULT1, res1, r);
      wr(`DLTH_OFF_CTRL, 32'h0A | (pol << 2), r);
      first = $urandom_range(1, 0);
      gap = $urandom_range(60, CAP + 20);
      fork
        plc.trigger(first);
        begin
          repeat (gap) @(posedge clk);
          plc.trigger(1 - first);
        end
      join
      for (int i = 0; i < 2; i++) begin
        cnt[i]++;
        chk("working length", len_b[i], 1 + CAP + PRC);
        chk("strobe length", len_s[i], SLEN);
        chk("strobe inside work", in_busy[i], 1);
      end
      chk("verdict0", line0_overall_verdict, res0[8] ^ pol[0]);
      chk("verdict1", line1_overall_verdict, res1[8] ^ pol[0]);
      chk("bits0", line0_result_bits, res0[7:0]);
      chk("bits1", line1_result_bits, res1[7:0]);
      rd(`DLTH_OFF_COUNT, d, r);
      chk("trigger count", d, {cnt[1][15:0], cnt[0][15:0]});
    end
    fork
      plc.trigger(0);
      plc.trigger(1);
    join
    cnt[0]++;
    cnt[1]++;
    chk("line0 first", len_b[0], 1 + CAP + PRC);
    chk("line1 waits", (len_b[1] - len_b[0]) inside {[CAP:CAP + 1]}, 1);
    wr(`DLTH_OFF_CTRL, 32'h02, r);
    wr(`DLTH_OFF_RESULT0, res0 ^ 32'hFF, r);
    plc.trigger(0);
    cnt[0]++;
    chk("no strobe", starts[0], 3);
    chk("bits kept", line0_result_bits, res0[7:0]);
    wr(`DLTH_OFF_CTRL, 32'h0B, r);
    repeat (2) @(posedge clk);
    chk("accept0 live", line0_accept_flag, 0);
    chk("accept1 live", line1_accept_flag, 0);
    plc.trigger(1);
    cnt[1]++;
    chk("live trigger taken", ends[1], 4);
    chk("live no error", trigger_error, 0);
    wr(`DLTH_OFF_CTRL, 32'h0A, r);
    repeat (2) @(posedge clk);
    chk("accept0 back", line0_accept_flag, 1);
    chk("accept1 back", line1_accept_flag, 1);
    // second rise while line 0 still works: controller misbehaving on purpose
    wr(`DLTH_OFF_PROCESS, 200, r);
    plc.pulse(0, 10);
    repeat (10) @(posedge clk);
    plc.pulse(0, 10);
    while (line0_working_flag) @(posedge clk);
    cnt[0]++;
    rd(`DLTH_OFF_COUNT, d, r);
    chk("busy trigger ignored", d, {cnt[1][15:0], cnt[0][15:0]});
    chk("error raised", trigger_error, 1);
    wr(`DLTH_OFF_ERROR, 32'h1, r);
    repeat (2) @(posedge clk);
    chk("error cleared", trigger_error, 0);
    for (int m = 0; m < 2; m++) begin
      wr(`DLTH_OFF_CTRL, 32'h08 | (m << 4), r);
      repeat (2) @(posedge clk);
      chk("run window pin", line1_working_flag, m[0]);
    end
    give_verdict();
  end
endmodule : dual_line_trigger_handshake_test

bind dlth_top dlth_asserts chk_u (.*);
